// ===== dv/i2c_master_model.sv
`timescale 1ns/1ps

// ==========================================================
// Bus master model: open drain, 4 clk low then 4 clk high per bit
module i2c_master_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// Data changes one clk after the fall, well clear of the target's 3 clk answer delay
	task bit_out(input logic b);
		step(1);
		sda_low = ~b;
		step(3);
		scl = 1'b1;
		step(4);
		scl = 1'b0;
	endtask : bit_out

	task bit_in(output logic b);
		step(1);
		sda_low = 1'b0;
		step(3);
		scl = 1'b1;
		step(2);
		b = sda;
		step(2);
		scl = 1'b0;
	endtask : bit_in

	// Also serves as repeated start
	task start();
		step(1);
		sda_low = 1'b0;
		step(3);
		scl = 1'b1;
		step(4);
		sda_low = 1'b1;
		step(4);
		scl = 1'b0;
	endtask : start

	task stop();
		step(1);
		sda_low = 1'b1;
		step(3);
		scl = 1'b1;
		step(4);
		sda_low = 1'b0;
		step(4);
	endtask : stop

	task wbyte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		bit_in(a);
		ack = ~a;
	endtask : wbyte

	task rbyte(input logic ack, output logic [7:0] b);
		logic x;
		for (int i = 0; i < 8; i++) begin
			bit_in(x);
			b = {b[6:0], x};
		end
		bit_out(~ack);
	endtask : rbyte
endmodule : i2c_master_model

// ===== dv/tb.sv
`timescale 1ns/1ps

module tb;
	logic clk;
	logic nrst;
	logic latch;
	logic flag;
	logic scl;
	logic m_low;
	logic sda;
	logic sda_out;
	logic sda_oe;
	logic [4:0] reg_addr;
	logic [15:0] reg_rdata;
	logic [15:0] dac_rdata;
	int bad_count;
	int num_checks;

	// ==========================================================
	// Register file stand-in: each word encodes its own address
	function automatic logic [15:0] regval(input logic [4:0] a);
		return {a, 3'h6, a, 3'h1};
	endfunction : regval

	function automatic logic [15:0] stat(input logic f);
		logic [15:0] v;
		v = regval(i2c_read_pkg::status_addr);
		v[i2c_read_pkg::flag_bit] = f;
		return v;
	endfunction : stat

	assign sda = ~(m_low | (sda_oe & ~sda_out));
	assign reg_rdata = regval(reg_addr);
	assign dac_rdata = ~regval(reg_addr);

	i2c_master_model i_i2c_master_model (
		.clk(clk),
		.sda(sda),
		.scl(scl),
		.sda_low(m_low)
	);

	i2c_register_read_path i_i2c_register_read_path (
		.clk(clk),
		.nrst(nrst),
		.scl_in(scl),
		.sda_in(sda),
		.output_latch_pin(latch),
		.eeprom_write_active_flag(flag),
		.reg_rdata(reg_rdata),
		.dac_out_rdata(dac_rdata),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.reg_addr(reg_addr)
	);

	always #50 clk = ~clk;

	// ==========================================================
	// Checking and bus helpers
	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wrap_up();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	task bus_stop();
		i_i2c_master_model.stop();
	endtask : bus_stop

	task cmd(input logic [7:0] c, input logic exp_ack);
		logic a;
		i_i2c_master_model.start();
		i_i2c_master_model.wbyte(8'hC0, a);
		check({15'h0, a}, 16'h0001);
		i_i2c_master_model.wbyte(c, a);
		check({15'h0, a}, {15'h0, exp_ack});
	endtask : cmd

	task open_rd(input logic exp_ack);
		logic a;
		i_i2c_master_model.start();
		i_i2c_master_model.wbyte(8'hC1, a);
		check({15'h0, a}, {15'h0, exp_ack});
	endtask : open_rd

	task rword(input logic last, input logic [15:0] exp);
		logic [7:0] m;
		logic [7:0] l;
		i_i2c_master_model.rbyte(1'b1, m);
		i_i2c_master_model.rbyte(~last, l);
		check({m, l}, exp);
	endtask : rword

	// ==========================================================
	// Scenarios
	task t_status();
		flag = 1'b1;
		cmd(8'h56, 1'b1);
		check({11'h0, reg_addr}, 16'h000A);
		open_rd(1'b1);
		rword(1'b0, stat(1'b1));
		flag = 1'b0;
		rword(1'b1, stat(1'b0));
		bus_stop();
		open_rd(1'b1);
		rword(1'b1, stat(1'b0));
		bus_stop();
	endtask : t_status

	task t_latch();
		for (int l = 0; l < 2; l++) begin
			latch = l[0];
			cmd(8'h1E, 1'b1);
			open_rd(1'b1);
			rword(1'b1, l[0] ? ~regval(5'h03) : regval(5'h03));
			bus_stop();
		end
		latch = 1'b0;
	endtask : t_latch

	task t_nv();
		cmd(8'h86, 1'b1);
		open_rd(1'b1);
		rword(1'b1, regval(5'h10));
		bus_stop();
		flag = 1'b1;
		open_rd(1'b0);
		bus_stop();
		cmd(8'h96, 1'b0);
		bus_stop();
		check({11'h0, reg_addr}, 16'h0010);
		flag = 1'b0;
	endtask : t_nv

	// Undefined code, unimplemented address and foreign target all fall off the bus
	task t_bad();
		logic a;
		cmd(8'h52, 1'b0);
		i_i2c_master_model.wbyte(8'h56, a);
		check({15'h0, a}, 16'h0000);
		bus_stop();
		check({11'h0, reg_addr}, 16'h0010);
		cmd(8'h66, 1'b0);
		bus_stop();
		i_i2c_master_model.start();
		i_i2c_master_model.wbyte(8'hC2, a);
		check({15'h0, a}, 16'h0000);
		bus_stop();
		cmd(8'h56, 1'b1);
		bus_stop();
		check({11'h0, reg_addr}, 16'h000A);
	endtask : t_bad

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		latch = 1'b0;
		flag = 1'b0;
		bad_count = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		#1;
		nrst = 1'b1;
		check({9'h0, sda_out, sda_oe, reg_addr}, 16'h0000);
		i_i2c_master_model.step(3);
		t_status();
		t_latch();
		t_nv();
		t_bad();
		wrap_up();
	end

	// Roughly 36 bytes of traffic take well under a third of this
	initial begin
		#3000000;
		bad_count++;
		wrap_up();
	end
endmodule : tb

// ===== hdl/i2c_read_pkg.sv
package i2c_read_pkg;

	// ==========================================================
	// Bus states, one-hot
	typedef enum logic [6:0] {
		st_idle = 7'h01,
		st_ctrl = 7'h02,
		st_cmd = 7'h04,
		st_ackout = 7'h08,
		st_tx = 7'h10,
		st_ackin = 7'h20,
		st_ignore = 7'h40
	} bus_state_t;

	// ==========================================================
	// Command byte layout, first bit on the wire is the MSB
	typedef struct packed {
		logic [4:0] register_address_field;
		logic [1:0] command_code_field;
		logic dont_care;
	} cmd_byte_t;

	// ==========================================================
	// Constants
	localparam logic [6:0] target_address_bits = 7'h60;
	localparam logic [1:0] cmd_read = 2'h3;
	localparam logic [3:0] bits_per_byte = 4'h8;
	localparam logic [4:0] dac_last_addr = 5'h07;
	localparam logic [4:0] status_addr = 5'h0A;
	localparam logic [4:0] vol_last_addr = 5'h0B;
	localparam logic [4:0] nv_first_addr = 5'h10;
	localparam logic [4:0] nv_last_addr = 5'h1B;
	localparam int flag_bit = 6;
	localparam logic [4:0] pointer_reset = 5'h00;
	localparam logic [15:0] word_reset = 16'h0000;

endpackage : i2c_read_pkg

// ===== hdl/i2c_register_read_path.sv
`timescale 1ns/1ps

// Function
// RQ1 - Master sends control, read command byte, restart, then control with read bit set.
// RQ2 - Read without command byte returns the last addressed register.
// RQ3 - Continuous read returns successive words while the master acknowledges.
// RQ4 - During a nonvolatile write only volatile locations may be read.
// RQ5 - Master ends continuous read with not-acknowledge then Stop or Restart.
// RQ6 - Status register holds the write-active flag, readable repeatedly.
// RQ7 - After a bad command release data line and ignore bus until Start.
// RQ8 - Words go out MSB byte first; command byte is address, code 11, spare.
// RQ9 - Last register address survives Start and Stop conditions.
// RQ10 - Invalid or unimplemented command is not acknowledged until next Start.
// RQ11 - Nonvolatile pointer during nonvolatile write answers with not-acknowledge.
// RQ12 - With latch pin high, DAC register reads return the live output value.
module i2c_register_read_path (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic output_latch_pin,
	input wire logic eeprom_write_active_flag,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] dac_out_rdata,
	output logic sda_out,
	output logic sda_oe,
	output logic [4:0] reg_addr
);

	logic [2:0] sync_q;
	logic scl_s, sda_s, latch_s;
	logic scl_d, sda_d, next_scl_d, next_sda_d;
	logic start_det, stop_det, scl_rise, scl_fall;

	i2c_read_pkg::bus_state_t state, next_state, after, next_after;
	logic [3:0] bitcnt, next_bitcnt;
	logic [7:0] shreg, next_shreg, txsh, next_txsh;
	logic [15:0] word, next_word, src_word;
	logic byte_hi, next_byte_hi, acked, next_acked;
	logic [4:0] next_pointer;
	logic next_sda_oe, next_sda_out;
	i2c_read_pkg::cmd_byte_t cmd;
	logic byte_done, addr_match, cmd_ok, cmd_accept, ptr_readable;

	function automatic logic is_nv(input logic [4:0] a);
		is_nv = (a >= i2c_read_pkg::nv_first_addr) && (a <= i2c_read_pkg::nv_last_addr);
	endfunction : is_nv

	// ==========================================================
	// Pin sampling and bus conditions
	sync2 #(.W(3)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.d({scl_in, sda_in, output_latch_pin}),
		.q(sync_q)
	);

	assign scl_s = sync_q[2];
	assign sda_s = sync_q[1];
	assign latch_s = sync_q[0];

	always_comb begin
		next_scl_d = scl_s;
		next_sda_d = sda_s;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
		end
	end

	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det = scl_s && scl_d && !sda_d && sda_s;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;

	// ==========================================================
	// Decoding
	assign cmd = i2c_read_pkg::cmd_byte_t'(shreg);
	assign byte_done = scl_fall && (bitcnt == i2c_read_pkg::bits_per_byte) && !start_det && !stop_det;
	assign addr_match = (shreg[7:1] == i2c_read_pkg::target_address_bits);
	// Only reads are served here; any other code counts as undefined
	assign cmd_ok = (cmd.command_code_field == i2c_read_pkg::cmd_read) // RQ8
		&& ((cmd.register_address_field <= i2c_read_pkg::vol_last_addr) || is_nv(cmd.register_address_field))
		&& !(is_nv(cmd.register_address_field) && eeprom_write_active_flag); // RQ4
	assign cmd_accept = (state == i2c_read_pkg::st_cmd) && byte_done && cmd_ok;
	assign ptr_readable = !(is_nv(reg_addr) && eeprom_write_active_flag); // RQ11

	always_comb begin
		src_word = reg_rdata;
		if ((reg_addr <= i2c_read_pkg::dac_last_addr) && latch_s) begin
			src_word = dac_out_rdata; // RQ12
		end
		if (reg_addr == i2c_read_pkg::status_addr) begin
			src_word[i2c_read_pkg::flag_bit] = eeprom_write_active_flag; // RQ6
		end
	end

	// ==========================================================
	// Bus state machine
	always_comb begin
		next_state = state;
		next_after = after;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_txsh = txsh;
		next_word = word;
		next_byte_hi = byte_hi;
		next_acked = acked;
		next_pointer = reg_addr;
		next_sda_out = 1'b0;
		if (start_det) begin
			// Repeated start lands here too; pointer is untouched
			next_state = i2c_read_pkg::st_ctrl; // RQ1
			next_bitcnt = 4'h0;
		end else if (stop_det) begin
			next_state = i2c_read_pkg::st_idle; // RQ9
		end else begin
			case (state)
				i2c_read_pkg::st_ctrl, i2c_read_pkg::st_cmd: begin
					if (scl_rise && (bitcnt != i2c_read_pkg::bits_per_byte)) begin
						next_shreg = {shreg[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (byte_done) begin
						next_state = i2c_read_pkg::st_ignore; // RQ7
						if (state == i2c_read_pkg::st_ctrl) begin
							if (addr_match && !shreg[0]) begin
								next_state = i2c_read_pkg::st_ackout;
								next_after = i2c_read_pkg::st_cmd;
							end else if (addr_match && ptr_readable) begin
								// Read without a command reuses the held pointer
								next_state = i2c_read_pkg::st_ackout; // RQ2
								next_after = i2c_read_pkg::st_tx;
								next_word = src_word;
								next_byte_hi = 1'b1;
							end
						end else if (cmd_accept) begin
							next_pointer = cmd.register_address_field; // RQ9
							next_state = i2c_read_pkg::st_ackout;
							next_after = i2c_read_pkg::st_cmd;
						end
					end
				end
				i2c_read_pkg::st_ackout: begin
					if (scl_fall) begin
						next_state = after;
						next_bitcnt = 4'h0;
						next_txsh = word[15:8]; // RQ8
					end
				end
				i2c_read_pkg::st_tx: begin
					if (scl_rise && (bitcnt != i2c_read_pkg::bits_per_byte)) begin
						next_bitcnt = bitcnt + 4'h1;
					end else if (byte_done) begin
						next_state = i2c_read_pkg::st_ackin;
					end else if (scl_fall) begin
						next_txsh = {txsh[6:0], 1'b1};
					end
				end
				i2c_read_pkg::st_ackin: begin
					if (scl_rise) begin
						next_acked = !sda_s;
					end else if (scl_fall) begin
						next_bitcnt = 4'h0;
						next_state = i2c_read_pkg::st_tx;
						if (!acked) begin
							next_state = i2c_read_pkg::st_ignore; // RQ5
						end else if (byte_hi) begin
							next_byte_hi = 1'b0;
							next_txsh = word[7:0]; // RQ8
						end else if (ptr_readable) begin
							// Same location again, so status can be polled in one transfer
							next_byte_hi = 1'b1; // RQ3
							next_word = src_word; // RQ6
							next_txsh = src_word[15:8];
						end else begin
							next_state = i2c_read_pkg::st_ignore; // RQ4
						end
					end
				end
				i2c_read_pkg::st_idle, i2c_read_pkg::st_ignore: begin
					next_state = state; // RQ10
				end
				default: begin
					next_state = i2c_read_pkg::st_idle;
				end
			endcase
		end
		// Open drain: only ever pull low, released everywhere else
		next_sda_oe = (next_state == i2c_read_pkg::st_ackout)
			|| ((next_state == i2c_read_pkg::st_tx) && !next_txsh[7]); // RQ7
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= i2c_read_pkg::st_idle;
			after <= i2c_read_pkg::st_idle;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			txsh <= 8'hFF;
			word <= i2c_read_pkg::word_reset;
			byte_hi <= 1'b0;
			acked <= 1'b0;
			reg_addr <= i2c_read_pkg::pointer_reset;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			state <= next_state;
			after <= next_after;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			txsh <= next_txsh;
			word <= next_word;
			byte_hi <= next_byte_hi;
			acked <= next_acked;
			reg_addr <= next_pointer;
			sda_oe <= next_sda_oe;
			sda_out <= next_sda_out;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_ctrl_read_taken;
		(state == i2c_read_pkg::st_ctrl) && byte_done && addr_match && shreg[0] && ptr_readable;
	endsequence
	sequence s_master_ack_msb;
		(state == i2c_read_pkg::st_ackin) && acked && byte_hi && scl_fall && !start_det && !stop_det;
	endsequence
	property p_last_addr_read;
		s_ctrl_read_taken |=> (state == i2c_read_pkg::st_ackout) && sda_oe && $stable(reg_addr) && byte_hi;
	endproperty
	a_last_addr_read: assert property (p_last_addr_read) else $error("read without command not served"); // RQ2

	property p_msb_first;
		((state == i2c_read_pkg::st_ackout) && (after == i2c_read_pkg::st_tx) && scl_fall && !start_det && !stop_det)
			|=> (state == i2c_read_pkg::st_tx) && (txsh == word[15:8]) && (sda_oe == !word[15]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("high byte not sent first"); // RQ8

	property p_lsb_follows;
		s_master_ack_msb |=> (state == i2c_read_pkg::st_tx) && (txsh == word[7:0]) && !byte_hi;
	endproperty
	a_lsb_follows: assert property (p_lsb_follows) else $error("low byte did not follow"); // RQ3

	property p_word_reload;
		((state == i2c_read_pkg::st_ackin) && acked && !byte_hi && scl_fall && !start_det && !stop_det && ptr_readable)
			|=> byte_hi && (word == $past(src_word));
	endproperty
	a_word_reload: assert property (p_word_reload) else $error("next word not reloaded"); // RQ3

	property p_status_flag;
		(s_ctrl_read_taken ##0 (reg_addr == i2c_read_pkg::status_addr))
			|=> word[i2c_read_pkg::flag_bit] == $past(eeprom_write_active_flag);
	endproperty
	a_status_flag: assert property (p_status_flag) else $error("status flag not reported"); // RQ6

	property p_latch_source;
		(s_ctrl_read_taken ##0 ((reg_addr <= i2c_read_pkg::dac_last_addr) && latch_s))
			|=> word == $past(dac_out_rdata);
	endproperty
	a_latch_source: assert property (p_latch_source) else $error("latched read not from output"); // RQ12

	property p_nv_blocked;
		((state == i2c_read_pkg::st_ctrl) && byte_done && addr_match && shreg[0] && !ptr_readable)
			|=> (state == i2c_read_pkg::st_ignore) && !sda_oe;
	endproperty
	a_nv_blocked: assert property (p_nv_blocked) else $error("nonvolatile read acknowledged in write"); // RQ11

	property p_cmd_nv_blocked;
		((state == i2c_read_pkg::st_cmd) && byte_done && is_nv(cmd.register_address_field) && eeprom_write_active_flag)
			|=> !sda_oe && (reg_addr == $past(reg_addr));
	endproperty
	a_cmd_nv_blocked: assert property (p_cmd_nv_blocked) else $error("nonvolatile command taken in write"); // RQ4

	property p_bad_cmd_nack;
		((state == i2c_read_pkg::st_cmd) && byte_done && !cmd_ok) |=> (state == i2c_read_pkg::st_ignore) && !sda_oe;
	endproperty
	a_bad_cmd_nack: assert property (p_bad_cmd_nack) else $error("invalid command acknowledged"); // RQ10

	property p_ignore_quiet;
		((state == i2c_read_pkg::st_ignore) && !start_det)
			|=> ((state == i2c_read_pkg::st_ignore) || (state == i2c_read_pkg::st_idle)) && !sda_oe;
	endproperty
	a_ignore_quiet: assert property (p_ignore_quiet) else $error("bus touched while ignoring"); // RQ7

	property p_pointer_kept;
		!cmd_accept |=> $stable(reg_addr);
	endproperty
	a_pointer_kept: assert property (p_pointer_kept) else $error("pointer changed without command"); // RQ9

endmodule : i2c_register_read_path

// ===== hdl/sync2.sv
`timescale 1ns/1ps

module sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// ==========================================================
	// Two-stage synchroniser; the first stage feeds only the second
	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end

endmodule : sync2
